/* File: tws_pkg.sv */
// shared types and constants for the two-wire memory slave
package tws_pkg;

	// ----------------------------------------
	// array geometry
	// ----------------------------------------
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 512;
	localparam logic [8:0] ADDR_RST = 9'h000;
	localparam logic [8:0] ADDR_LAST = 9'h1FF;
	localparam logic [8:0] ADDR_STEP = 9'h001;

	// ----------------------------------------
	// slave address fields
	// ----------------------------------------
	localparam int SA_TYPE_HI = 7;
	localparam int SA_TYPE_LO = 4;
	localparam int SA_SEL_HIGH = 3;
	localparam int SA_SEL_LOW = 2;
	localparam int SA_PAGE = 1;
	localparam int SA_RW = 0;

	// ----------------------------------------
	// bit counting
	// ----------------------------------------
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_STEP = 3'h1;

	// ----------------------------------------
	// carriers and states
	// ----------------------------------------
	typedef struct packed {
		logic scl;
		logic sda;
		logic wp;
		logic sel_high;
		logic sel_low;
	} tws_pins_t;

	// idle bus level: both lines pulled high, straps and protection low
	localparam tws_pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, wp: 1'b0, sel_high: 1'b0, sel_low: 1'b0};

	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} tws_ev_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_WORD,
		ST_WR,
		ST_ACK,
		ST_RD,
		ST_RDACK
	} tws_state_t;

endpackage

/* File: tws_sync.sv */
// pin synchroniser and bus event detector
`timescale 1ns/10ps
module tws_sync (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// raw pins
	input wire tws_pkg::tws_pins_t i_pins,
	// synchronised levels and events
	output tws_pkg::tws_pins_t o_pins,
	output tws_pkg::tws_ev_t o_ev
);

	tws_pkg::tws_pins_t meta_r;
	tws_pkg::tws_pins_t sync_r;
	tws_pkg::tws_pins_t prev_r;

	// first stage feeds only the second stage
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			// reset to the idle bus level so release shows no false edge
			meta_r <= tws_pkg::PINS_IDLE;
			sync_r <= tws_pkg::PINS_IDLE;
			prev_r <= tws_pkg::PINS_IDLE;
		end else begin
			meta_r <= i_pins;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign o_pins = sync_r;

	// start and stop need scl high on both samples so a clock edge
	// coinciding with data is never taken as a condition
	always_comb begin
		o_ev.scl_rise = sync_r.scl && !prev_r.scl;
		o_ev.scl_fall = !sync_r.scl && prev_r.scl;
		o_ev.start = sync_r.scl && prev_r.scl && prev_r.sda && !sync_r.sda;
		o_ev.stop = sync_r.scl && prev_r.scl && !prev_r.sda && sync_r.sda;
	end

endmodule // tws_sync

/* File: tws_mem.sv */
// 512 x 8 storage array with registered read
`timescale 1ns/10ps
module tws_mem (
	// clock
	input wire logic i_clk,
	// write port
	input wire logic i_we,
	input wire logic [8:0] i_addr,
	input wire logic [7:0] i_wdata,
	// read port
	output logic [7:0] o_rdata
);

	logic [7:0] mem [tws_pkg::MEM_DEPTH];

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
		end
	end

	// read follows the address one cycle late; the bus is far slower
	always_ff @(posedge i_clk) begin
		o_rdata <= mem[i_addr];
	end

endmodule // tws_mem

/* File: tws_slave.sv */
// two-wire serial slave front end of a 512 x 8 memory
//
// Contract
// - stop with scl high aborts any pending operation, back to idle.
// - start with scl high aborts anything and awaits a slave address.
// - after eight bits transmitter releases sda, receiver pulls low to ack.
// - sda left high in ack clock ends the operation.
// - first byte after start is slave address; upper nibble must match type.
// - address bits 3 and 2 must equal high and low select pins.
// - address bit 1 picks the 256-byte half, top address bit.
// - address bit 0 gives direction, zero write, one read.
// - write sends low address byte, latched with page bit as nine bits.
// - read takes no address byte, uses latch plus page bit.
// - address increments just before each data ack, 1FFh wraps to 000h.
// - no limit on consecutive bytes in one operation.
// - every byte shifts most significant bit first.
// - read drives eight bits, samples ack, continues on ack, ends otherwise.
// - write stores byte on its eighth bit before driving the ack.
// - start or stop before the eighth bit leaves memory unchanged.
// - new transaction accepted right after a write, no busy time.
// - write protect high blocks every write and data byte ack.
// - write protect keeps the address counter still on attempted writes.
// - sda changes after scl falls, input sampled on scl rise.
// - sda is open drain, only pulled low or released.
`timescale 1ns/10ps
module tws_slave #(
	// device type code; value is arbitrary
	parameter logic [3:0] P_DEV_TYPE = 4'h5
) (
	// clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	// two-wire bus
	input wire logic I_SCL,
	input wire logic I_SDA,
	output logic O_SDA_OUT,
	output logic O_SDA_OE,
	// straps and protection
	input wire logic I_WP,
	input wire logic I_SELECT_PIN_HIGH,
	input wire logic I_SELECT_PIN_LOW
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	tws_pkg::tws_pins_t pins_raw;
	tws_pkg::tws_pins_t pins;
	tws_pkg::tws_ev_t ev;
	tws_pkg::tws_state_t state_r;
	tws_pkg::tws_state_t next_r;
	logic [2:0] bit_cnt_r;
	logic [7:0] rx_r;
	logic [7:0] tx_r;
	logic [8:0] addr_r;
	logic byte_done_r;
	logic wr_ok_r;
	logic ack_seen_r;
	logic sda_oe_r;
	logic sda_o_r;
	logic receiving;
	logic last_rise;
	logic rx_fall;
	logic match;
	logic ack_go;
	logic mem_we;
	logic [7:0] rx_byte;
	logic [7:0] rd_data;

	function automatic logic addr_match(
		input logic [7:0] b,
		input logic hi,
		input logic lo
	);
		addr_match = (b[tws_pkg::SA_TYPE_HI:tws_pkg::SA_TYPE_LO] == P_DEV_TYPE)
			&& (b[tws_pkg::SA_SEL_HIGH] == hi)
			&& (b[tws_pkg::SA_SEL_LOW] == lo);
	endfunction

	// ----------------------------------------
	// pins and storage
	// ----------------------------------------
	assign pins_raw = {I_SCL, I_SDA, I_WP, I_SELECT_PIN_HIGH, I_SELECT_PIN_LOW};

	tws_sync u_sync (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RST_N),
		.i_pins(pins_raw),
		.o_pins(pins),
		.o_ev(ev)
	);

	tws_mem u_mem (
		.i_clk(I_CLK_SYS),
		.i_we(mem_we),
		.i_addr(addr_r),
		.i_wdata(rx_byte),
		.o_rdata(rd_data)
	);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	always_comb begin
		receiving = (state_r == tws_pkg::ST_ADDR) || (state_r == tws_pkg::ST_WORD)
			|| (state_r == tws_pkg::ST_WR);
		rx_byte = {rx_r[6:0], pins.sda};
		last_rise = receiving && ev.scl_rise && (bit_cnt_r == tws_pkg::BIT_LAST);
		rx_fall = receiving && ev.scl_fall && byte_done_r;
		match = addr_match(rx_r, pins.sel_high, pins.sel_low);
		// store only on the eighth rise, so an early start or stop writes nothing
		mem_we = (state_r == tws_pkg::ST_WR) && last_rise && !pins.wp;
		case (state_r)
			tws_pkg::ST_ADDR: ack_go = match;
			tws_pkg::ST_WORD: ack_go = 1'b1;
			tws_pkg::ST_WR: ack_go = wr_ok_r;
			default: ack_go = 1'b0;
		endcase
	end

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			state_r <= tws_pkg::ST_IDLE;
			next_r <= tws_pkg::ST_IDLE;
		end else if (ev.start) begin
			state_r <= tws_pkg::ST_ADDR;
		end else if (ev.stop) begin
			state_r <= tws_pkg::ST_IDLE;
		end else begin
			case (state_r)
				tws_pkg::ST_ADDR: begin
					if (rx_fall && match) begin
						state_r <= tws_pkg::ST_ACK;
						next_r <= rx_r[tws_pkg::SA_RW] ? tws_pkg::ST_RD : tws_pkg::ST_WORD;
					end else if (rx_fall) begin
						state_r <= tws_pkg::ST_IDLE;
					end
				end
				tws_pkg::ST_WORD: begin
					if (rx_fall) begin
						state_r <= tws_pkg::ST_ACK;
						next_r <= tws_pkg::ST_WR;
					end
				end
				tws_pkg::ST_WR: begin
					if (rx_fall) begin
						state_r <= tws_pkg::ST_ACK;
						// keep looping while writes are allowed, no byte limit
						next_r <= wr_ok_r ? tws_pkg::ST_WR : tws_pkg::ST_IDLE;
					end
				end
				tws_pkg::ST_ACK: begin
					if (ev.scl_fall) begin
						state_r <= next_r;
					end
				end
				tws_pkg::ST_RD: begin
					if (ev.scl_fall && (bit_cnt_r == tws_pkg::BIT_LAST)) begin
						state_r <= tws_pkg::ST_RDACK;
					end
				end
				tws_pkg::ST_RDACK: begin
					if (ev.scl_fall) begin
						state_r <= ack_seen_r ? tws_pkg::ST_RD : tws_pkg::ST_IDLE;
					end
				end
				default: begin
					state_r <= tws_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// bit counting and shifting
	// ----------------------------------------
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N || ev.start || ev.stop) begin
			bit_cnt_r <= tws_pkg::BIT_FIRST;
		end else if (receiving && ev.scl_rise) begin
			bit_cnt_r <= bit_cnt_r + tws_pkg::BIT_STEP;
		end else if ((state_r == tws_pkg::ST_RD) && ev.scl_fall) begin
			bit_cnt_r <= bit_cnt_r + tws_pkg::BIT_STEP;
		end else if (!receiving && (state_r != tws_pkg::ST_RD)) begin
			bit_cnt_r <= tws_pkg::BIT_FIRST;
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			rx_r <= 8'h00;
		end else if (receiving && ev.scl_rise) begin
			rx_r <= rx_byte;
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N || ev.start || ev.stop) begin
			byte_done_r <= 1'b0;
			wr_ok_r <= 1'b0;
		end else if (last_rise) begin
			byte_done_r <= 1'b1;
			wr_ok_r <= !pins.wp;
		end else if (ev.scl_fall) begin
			byte_done_r <= 1'b0;
		end
	end

	// master acknowledge sampled on the ninth rise of a read byte
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			ack_seen_r <= 1'b0;
		end else if ((state_r == tws_pkg::ST_RDACK) && ev.scl_rise) begin
			ack_seen_r <= !pins.sda;
		end
	end

	// ----------------------------------------
	// address latch
	// ----------------------------------------
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			addr_r <= tws_pkg::ADDR_RST;
		end else if ((state_r == tws_pkg::ST_ADDR) && rx_fall && match) begin
			addr_r[8] <= rx_r[tws_pkg::SA_PAGE];
		end else if ((state_r == tws_pkg::ST_WORD) && rx_fall) begin
			addr_r[7:0] <= rx_r;
		end else if (mem_we) begin
			addr_r <= addr_r + tws_pkg::ADDR_STEP;
		end else if ((state_r == tws_pkg::ST_RD) && ev.scl_fall
			&& (bit_cnt_r == tws_pkg::BIT_LAST)) begin
			addr_r <= addr_r + tws_pkg::ADDR_STEP;
		end
	end

	// ----------------------------------------
	// sda driver
	// ----------------------------------------
	// the pad only ever pulls low; releasing lets the pull-up win
	always_ff @(posedge I_CLK_SYS) begin
		sda_o_r <= 1'b0;
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			tx_r <= 8'h00;
		end else if (ev.scl_fall && (((state_r == tws_pkg::ST_ACK)
			&& (next_r == tws_pkg::ST_RD)) || (state_r == tws_pkg::ST_RDACK))) begin
			tx_r <= rd_data;
		end else if ((state_r == tws_pkg::ST_RD) && ev.scl_fall) begin
			tx_r <= {tx_r[6:0], 1'b0};
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N || ev.start || ev.stop) begin
			sda_oe_r <= 1'b0;
		end else if (ev.scl_fall) begin
			case (state_r)
				tws_pkg::ST_ADDR, tws_pkg::ST_WORD, tws_pkg::ST_WR: begin
					sda_oe_r <= byte_done_r && ack_go;
				end
				tws_pkg::ST_ACK: begin
					sda_oe_r <= (next_r == tws_pkg::ST_RD) && !rd_data[7];
				end
				tws_pkg::ST_RD: begin
					// release for the master acknowledge after the eighth bit
					sda_oe_r <= (bit_cnt_r != tws_pkg::BIT_LAST) && !tx_r[6];
				end
				tws_pkg::ST_RDACK: begin
					sda_oe_r <= ack_seen_r && !rd_data[7];
				end
				default: begin
					sda_oe_r <= 1'b0;
				end
			endcase
		end
	end

	assign O_SDA_OUT = sda_o_r;
	assign O_SDA_OE = sda_oe_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);

	stop_to_idle_a: assert property (ev.stop && !ev.start
		|=> state_r == tws_pkg::ST_IDLE && !sda_oe_r)
		else $error("stop did not return to idle");

	start_to_addr_a: assert property (ev.start
		|=> state_r == tws_pkg::ST_ADDR && bit_cnt_r == 3'h0 && !sda_oe_r)
		else $error("start did not rearm address reception");

	oe_after_fall_a: assert property ($rose(sda_oe_r)
		|-> $past(ev.scl_fall) && !pins.scl)
		else $error("sda drive began outside scl low");

	addr_ack_a: assert property ((state_r == tws_pkg::ST_ADDR) && rx_fall && match
		&& !ev.start && !ev.stop |=> sda_oe_r && state_r == tws_pkg::ST_ACK)
		else $error("matched slave address not acknowledged");

	mismatch_quiet_a: assert property ((state_r == tws_pkg::ST_ADDR) && rx_fall
		&& !match && !ev.start |=> !sda_oe_r && state_r == tws_pkg::ST_IDLE)
		else $error("unmatched address drove the bus");

	wp_no_store_a: assert property (pins.wp && (state_r == tws_pkg::ST_WR)
		|-> !mem_we)
		else $error("write while protected");

	wp_nack_a: assert property ((state_r == tws_pkg::ST_WR) && rx_fall && !wr_ok_r
		|=> !sda_oe_r)
		else $error("protected data byte acknowledged");

	wp_addr_hold_a: assert property ((state_r == tws_pkg::ST_WR) && last_rise
		&& pins.wp && !ev.start |=> $stable(addr_r))
		else $error("address moved under write protect");

	addr_wrap_a: assert property (mem_we && addr_r == 9'h1FF
		|=> addr_r == 9'h000)
		else $error("address did not wrap");

	read_nack_end_a: assert property ((state_r == tws_pkg::ST_RDACK) && ev.scl_fall
		&& !ack_seen_r && !ev.start |=> state_r == tws_pkg::ST_IDLE ##1 !sda_oe_r)
		else $error("read continued after no acknowledge");

	idle_released_a: assert property (state_r == tws_pkg::ST_IDLE |-> !sda_oe_r)
		else $error("sda driven while idle");

	write_cov_c: cover property (mem_we ##[1:200] state_r == tws_pkg::ST_ACK && sda_oe_r);
	read_more_c: cover property ((state_r == tws_pkg::ST_RDACK) && ev.scl_fall && ack_seen_r);
	sel_read_c: cover property ((state_r == tws_pkg::ST_WR) && ev.start);
	wp_nack_c: cover property ((state_r == tws_pkg::ST_WR) && last_rise && pins.wp);

endmodule // tws_slave

/* File: tws_bus_master.sv */
// behavioural two-wire bus master that drives the slave's far side
`timescale 1ns/10ps
module tws_bus_master (
	// clock
	input wire logic i_clk,
	// resolved data line
	input wire logic i_sda,
	// bus drive
	output logic o_scl,
	output logic o_sda_oe
);
	// extra low-phase cycles, set by the bench to slow the bus down
	int stall = 0;

	// scl stands high and sda is released outside frames
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge i_clk);
	endtask

	// data changes only while scl is low and is sampled late in the high phase
	task automatic clk_bit(input logic b, output logic s);
		tick(1);
		o_sda_oe = ~b;
		tick(3 + stall);
		o_scl = 1'b1;
		tick(3);
		s = i_sda;
		tick(1);
		o_scl = 1'b0;
	endtask

	// also a repeated start; the wait lets a slave ack release first
	task automatic bus_start();
		tick(1);
		o_sda_oe = 1'b0;
		tick(5);
		o_scl = 1'b1;
		tick(4);
		o_sda_oe = 1'b1;
		tick(4);
		o_scl = 1'b0;
	endtask

	task automatic bus_stop();
		tick(1);
		o_sda_oe = 1'b1;
		tick(5);
		o_scl = 1'b1;
		tick(4);
		o_sda_oe = 1'b0;
		tick(4);
	endtask

	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(b[i], s);
		end
		clk_bit(1'b1, ack);
	endtask

	// a partial byte, used to abandon a write
	task automatic put_half(input logic [3:0] b);
		logic s;
		for (int i = 3; i >= 0; i--) begin
			clk_bit(b[i], s);
		end
	endtask

	task automatic get_byte(output logic [7:0] b, input logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, b[i]);
		end
		clk_bit(~ack, s);
	endtask
endmodule // tws_bus_master

/* File: test_two_wire_memory_slave_512x8.sv */
// self-checking bench for the two-wire memory slave
`timescale 1ns/10ps
module test_two_wire_memory_slave_512x8;
	// type code; value is arbitrary
	localparam logic [3:0] DEV = 4'h5;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wp = 1'b0;
	logic sel_high = 1'b0;
	logic sel_low = 1'b0;
	logic dut_out;
	logic dut_oe;
	logic mst_scl;
	logic mst_oe;
	// pull-up line: low whenever either party pulls it
	wire sda = (dut_oe ? dut_out : 1'b1) & ~mst_oe;
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	logic [7:0] exp_mem [512];
	logic [8:0] exp_addr = 9'h000;
	logic ack;
	logic [7:0] rd;

	initial forever #2 clk = ~clk;

	tws_slave #(.P_DEV_TYPE(DEV)) DUT (
		.I_CLK_SYS(clk),
		.I_RST_N(rst_n),
		.I_SCL(mst_scl),
		.I_SDA(sda),
		.O_SDA_OUT(dut_out),
		.O_SDA_OE(dut_oe),
		.I_WP(wp),
		.I_SELECT_PIN_HIGH(sel_high),
		.I_SELECT_PIN_LOW(sel_low)
	);

	tws_bus_master MST (.i_clk(clk), .i_sda(sda), .o_scl(mst_scl), .o_sda_oe(mst_oe));

	// ----------------------------------------
	// expectations and comparisons
	// ----------------------------------------
	function automatic logic [7:0] slave_byte(input logic page, input logic dir);
		return {DEV, sel_high, sel_low, page, dir};
	endfunction

	function automatic logic [8:0] next_addr(input logic [8:0] a);
		return (a == 9'h1FF) ? 9'h000 : a + 9'h001;
	endfunction

	task automatic chk_bit(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %b", $time, what, got);
		end
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// transactions
	// ----------------------------------------
	task automatic open_wr(input logic [8:0] a);
		MST.bus_start();
		MST.put_byte(slave_byte(a[8], 1'b0), ack);
		chk_bit(ack, 1'b0, "write address ack");
		MST.put_byte(a[7:0], ack);
		chk_bit(ack, 1'b0, "word ack");
		exp_addr = a;
	endtask

	task automatic write_seq(input logic [8:0] a, input int n);
		logic [7:0] d;
		open_wr(a);
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			MST.put_byte(d, ack);
			chk_bit(ack, 1'b0, "data ack");
			exp_mem[exp_addr] = d;
			exp_addr = next_addr(exp_addr);
		end
		MST.bus_stop();
	endtask

	task automatic read_seq(input logic page, input int n);
		MST.bus_start();
		MST.put_byte(slave_byte(page, 1'b1), ack);
		chk_bit(ack, 1'b0, "read address ack");
		exp_addr[8] = page;
		for (int i = 0; i < n; i++) begin
			MST.get_byte(rd, i < n - 1);
			chk_byte(rd, exp_mem[exp_addr], "read data");
			exp_addr = next_addr(exp_addr);
		end
		repeat (6) @(negedge clk);
		chk_bit(dut_oe, 1'b0, "release after nack");
		MST.bus_stop();
	endtask

	// the run is cut short if the bus hangs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			errors++;
			$display("unexpected at %0t: timeout", $time);
			report_and_stop();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h0A7C));
		repeat (10) @(negedge clk);
		chk_bit(dut_oe, 1'b0, "oe in reset");
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk_bit(dut_out, 1'b0, "open drain level");
		// a matching byte clocked without a start must be ignored
		MST.o_scl = 1'b0;
		MST.put_byte(slave_byte(1'b0, 1'b0), ack);
		chk_bit(ack, 1'b1, "byte without start");
		MST.bus_stop();
		$display("test reset done");

		for (int t = 0; t < 4; t++) begin : rnd
			logic [8:0] a;
			int n;
			a = 9'($urandom);
			n = 1 + $urandom % 16;
			{sel_high, sel_low} = 2'($urandom);
			MST.stall = $urandom % 4;
			write_seq(a, n);
			open_wr(a);
			read_seq(a[8], n);
		end
		MST.stall = 0;
		$display("test random done");

		write_seq(9'h1FE, 4);
		open_wr(9'h1FE);
		read_seq(1'b1, 4);
		write_seq(9'h0FF, 1);
		read_seq(1'b0, 1);
		$display("test wrap done");

		for (int k = 0; k < 3; k++) begin
			MST.bus_start();
			MST.put_byte(slave_byte(1'b0, 1'b0) ^ (8'h10 >> k), ack);
			chk_bit(ack, 1'b1, "foreign address");
			MST.put_byte(8'h00, ack);
			chk_bit(ack, 1'b1, "idle after foreign address");
			MST.bus_stop();
		end
		$display("test select done");

		wp = 1'b1;
		open_wr(9'h1FF);
		MST.put_byte(~exp_mem[9'h1FF], ack);
		chk_bit(ack, 1'b1, "protected data ack");
		MST.bus_stop();
		wp = 1'b0;
		read_seq(1'b1, 1);
		$display("test protect done");

		open_wr(9'h000);
		MST.put_half(4'hA);
		read_seq(1'b0, 1);
		open_wr(9'h1FE);
		MST.put_half(4'h5);
		MST.bus_stop();
		read_seq(1'b1, 1);
		$display("test abort done");

		// reset in mid-write: bus released, address latch back to zero
		open_wr(9'h0A5);
		rst_n = 1'b0;
		repeat (10) @(negedge clk);
		chk_bit(dut_oe, 1'b0, "oe in mid-run reset");
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		exp_addr = 9'h000;
		read_seq(1'b0, 1);
		$display("test mid reset done");
		report_and_stop();
	end
endmodule // test_two_wire_memory_slave_512x8
